// ===== mur_pkg.sv
// shared constants and types for the measurement register access block
package mur_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths and control/status byte layout
    localparam int DATA_W        = 16;
    localparam int CTRL_W        = 8;
    localparam int NUM_W         = 6;
    localparam int ESCALE_W      = 3;
    localparam int CTRL_MODE_BIT = 7;
    localparam int CTRL_WR_BIT   = 6;
    localparam logic [7:0] CTRL_WR_MASK  = 8'h40;
    localparam logic [7:0] STAT_ERR_MASK = 8'h40;

    ////////////////////////////////////////////////////////////////////////
    // register numbers as carried in the control byte
    localparam logic [5:0] REG_FW     = 6'h09;
    localparam logic [5:0] REG_CODE   = 6'h1F;
    localparam logic [5:0] REG_FEAT   = 6'h20;
    localparam logic [5:0] REG_ESCALE = 6'h23;
    localparam logic [5:0] REG_UVTH   = 6'h24;
    localparam logic [5:0] REG_TDIV   = 6'h25;
    localparam logic [5:0] REG_MMPER  = 6'h26;
    localparam logic [5:0] REG_MCYC   = 6'h27;

    ////////////////////////////////////////////////////////////////////////
    // storage slots for the user registers, with defaults and masks
    localparam int SLOT_N = 6;
    localparam logic [2:0] S_FEAT    = 3'h0;
    localparam logic [2:0] S_ESCALE  = 3'h1;
    localparam logic [2:0] S_UVTH    = 3'h2;
    localparam logic [2:0] S_TDIV    = 3'h3;
    localparam logic [2:0] S_MMPER   = 3'h4;
    localparam logic [2:0] S_MCYC    = 3'h5;
    localparam logic [2:0] SLOT_NONE = 3'h7;
    localparam logic [15:0] SLOT_RST [SLOT_N] = '{16'h0000, 16'h0004,
        16'h0064, 16'h0001, 16'h00C8, 16'h0032};
    localparam logic [15:0] SLOT_MASK [SLOT_N] = '{16'h00FD, 16'hFFFF,
        16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
    localparam int FEAT_SCALE_BIT   = 0;
    localparam int FEAT_AUTOCLR_BIT = 7;
    localparam logic [15:0] ESCALE_MAX  = 16'h0006;
    localparam logic [15:0] CODE_UNLOCK = 16'h1235;
    localparam logic [15:0] CODE_RST    = 16'h0000;
    // arbitrary neutral revision text, two ascii characters
    localparam logic [15:0] FW_REV_DEF  = 16'h3030;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int MINMAX_RES_MS = 10;
    localparam int TMR_W         = 20;

    typedef enum logic {MUR_DIV_IDLE, MUR_DIV_RUN} mur_div_state_t;

endpackage

// ===== mur_div_if.sv
// request and answer signals of the current divider
`timescale 1ns/1ps
interface mur_div_if;
    logic                          start;
    logic [mur_pkg::DATA_W-1:0]    dividend;
    logic [mur_pkg::DATA_W-1:0]    divisor;
    logic                          busy;
    logic                          done;
    logic [mur_pkg::DATA_W-1:0]    quotient;
    modport req (output start, dividend, divisor,
                 input  busy, done, quotient);
    modport srv (input  start, dividend, divisor,
                 output busy, done, quotient);
endinterface

// ===== mur_divider.sv
// sequential restoring divider for transformer ratio scaling
`timescale 1ns/1ps
module mur_divider (
    input  wire logic   sys_clk,
    input  wire logic   srst,
    mur_div_if.srv      div
);
    localparam int W = mur_pkg::DATA_W;
    localparam int CW = $clog2(W);

    mur_pkg::mur_div_state_t state_q;
    logic [W-1:0]            rem_q;
    logic [W-1:0]            quo_q;
    logic [W-1:0]            dsr_q;
    logic [CW-1:0]           cnt_q;
    logic                    done_q;
    logic [W:0]              trial;

    // one quotient bit per cycle, trial subtract of shifted remainder
    assign trial = {rem_q, quo_q[W-1]} - {1'b0, dsr_q};

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= mur_pkg::MUR_DIV_IDLE;
            rem_q   <= '0;
            quo_q   <= '0;
            dsr_q   <= '0;
            cnt_q   <= '0;
            done_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                mur_pkg::MUR_DIV_IDLE: begin
                    if (div.start) begin
                        rem_q   <= '0;
                        quo_q   <= div.dividend;
                        dsr_q   <= div.divisor;
                        cnt_q   <= '0;
                        state_q <= mur_pkg::MUR_DIV_RUN;
                    end
                end
                mur_pkg::MUR_DIV_RUN: begin
                    if (!trial[W]) begin
                        rem_q <= trial[W-1:0];
                        quo_q <= {quo_q[W-2:0], 1'b1};
                    end else begin
                        rem_q <= {rem_q[W-2:0], quo_q[W-1]};
                        quo_q <= {quo_q[W-2:0], 1'b0};
                    end
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CW'(W - 1)) begin
                        done_q  <= 1'b1;
                        state_q <= mur_pkg::MUR_DIV_IDLE;
                    end
                end
                default: state_q <= mur_pkg::MUR_DIV_IDLE;
            endcase
        end
    end

    assign div.busy     = (state_q == mur_pkg::MUR_DIV_RUN);
    assign div.done     = done_q;
    assign div.quotient = quo_q;
endmodule

// ===== mur_interval.sv
// interval timer counting millisecond ticks up to a programmed period
`timescale 1ns/1ps
module mur_interval #(
    parameter int CNT_W = mur_pkg::TMR_W
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic             tick,
    input  wire logic             enable,
    input  wire logic [CNT_W-1:0] period,
    output logic                  fire_q
);
    logic [CNT_W-1:0] cnt_q;

    // a period of zero acts as one tick, the shortest legal interval
    always_ff @(posedge sys_clk) begin
        if (srst || !enable) begin
            cnt_q  <= '0;
            fire_q <= 1'b0;
        end else begin
            fire_q <= 1'b0;
            if (tick) begin
                if (cnt_q + 1'b1 >= period) begin
                    cnt_q  <= '0;
                    fire_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

    AST_FIRE_ON_TICK: assert property (@(posedge sys_clk) disable iff (srst)
        fire_q |-> $past(tick) && $past(enable))
        else $error("interval fired without a tick");
endmodule

// ===== mur_regaccess.sv
// register access path and user registers of the power measurement unit
`timescale 1ns/1ps
// Function
// - energy scale entries 0..6, above reserved, default 4
// - voltage below threshold sets error flag, led
// - current divided by divisor only when enabled
// - min/max cleared after period when enabled
// - measuring cycle in ms steps, default 50
// - control bit 7 selects register mode
// - control bit 6 one writes, zero reads
// - control bits 5..0 give register number
// - read returns register value, output word ignored
// - read acknowledged by echoing control byte
// - write acknowledged with bit 6 cleared
// - input word meaningless after a write
// - protected: only code register is writable
// - unlock code lifts protection, else restores
// - new values act only after restart
// - code register reads back last written code
// - firmware register returns two ascii characters
// - code cleared on every restart
// - feature bit 7 autoclear, bit 0 scaling
// - unlocked writes also go to nonvolatile store
module mur_regaccess #(
    parameter int               MS_CYCLES = mur_pkg::MS_CYCLES,
    parameter logic [15:0]      FW_REV    = mur_pkg::FW_REV_DEF
) (
    input  wire logic           sys_clk,
    input  wire logic           srst,
    input  wire logic           nvm_init,
    input  wire logic           pd_strobe,
    input  wire logic [7:0]     ctrl_byte,
    input  wire logic [15:0]    host_output_word,
    input  wire logic [15:0]    mains_voltage,
    input  wire logic [15:0]    meas_current,
    output logic [7:0]          status_byte_q,
    output logic [15:0]         device_input_word_q,
    output logic                err_led_q,
    output logic [2:0]          energy_scale_q,
    output logic [15:0]         scaled_current_q,
    output logic                measure_tick_q,
    output logic                minmax_clear_q
);
    localparam int PS_W = $clog2(MS_CYCLES);
    logic [5:0]  acc_num;
    logic        acc_wr;
    logic        acc_go;
    logic        held_q;
    logic [7:0]  last_ctrl_q;
    logic [15:0] code_q;
    logic        locked;
    logic [2:0]  wr_slot;
    logic        value_ok;
    logic        wr_en;
    logic [15:0] rd_data;
    logic [15:0] wdata;
    logic [15:0] vol_q [mur_pkg::SLOT_N];
    logic [15:0] nv_q  [mur_pkg::SLOT_N];
    logic [15:0] act_q [mur_pkg::SLOT_N];
    logic        scale_en;
    logic [PS_W-1:0] ms_cnt_q;
    logic        ms_tick_q;
    logic        meas_fire;
    logic        mm_fire;
    mur_div_if div ();
    // map a register number onto its storage slot
    function automatic logic [2:0] slot_of(input logic [5:0] n);
        if (n == mur_pkg::REG_FEAT) begin
            slot_of = mur_pkg::S_FEAT;
        end else if (n == mur_pkg::REG_ESCALE) begin
            slot_of = mur_pkg::S_ESCALE;
        end else if (n == mur_pkg::REG_UVTH) begin
            slot_of = mur_pkg::S_UVTH;
        end else if (n == mur_pkg::REG_TDIV) begin
            slot_of = mur_pkg::S_TDIV;
        end else if (n == mur_pkg::REG_MMPER) begin
            slot_of = mur_pkg::S_MMPER;
        end else if (n == mur_pkg::REG_MCYC) begin
            slot_of = mur_pkg::S_MCYC;
        end else begin
            slot_of = mur_pkg::SLOT_NONE;
        end
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // control byte decode
    // register number field
    assign acc_num = ctrl_byte[mur_pkg::NUM_W-1:0];
    assign acc_wr  = ctrl_byte[mur_pkg::CTRL_WR_BIT];
    // register mode, act only on a changed control byte
    assign acc_go  = pd_strobe && ctrl_byte[mur_pkg::CTRL_MODE_BIT]
                     && (!held_q || ctrl_byte != last_ctrl_q);
    // remember the access in progress so a repeated byte is not redone
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            held_q      <= 1'b0;
            last_ctrl_q <= 8'h00;
        end else if (pd_strobe) begin
            held_q      <= ctrl_byte[mur_pkg::CTRL_MODE_BIT];
            last_ctrl_q <= ctrl_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protection code register
    // cleared on restart; any write to it is taken
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            code_q <= mur_pkg::CODE_RST;
        end else if (acc_go && acc_wr && acc_num == mur_pkg::REG_CODE) begin
            code_q <= host_output_word;
        end
    end
    // only the unlock value lifts protection
    assign locked = (code_q != mur_pkg::CODE_UNLOCK);
    ////////////////////////////////////////////////////////////////////////
    // user register write path
    assign wr_slot = slot_of(acc_num);
    assign wdata   = host_output_word & mur_pkg::SLOT_MASK[wr_slot];
    assign value_ok = (wr_slot != mur_pkg::S_ESCALE)
                      || (host_output_word <= mur_pkg::ESCALE_MAX);
    // protected registers refuse writes; unmapped ignored
    assign wr_en = acc_go && acc_wr && !locked && value_ok
                   && (wr_slot != mur_pkg::SLOT_NONE);
    // volatile, nonvolatile and active copy of each user register
    for (genvar i = 0; i < mur_pkg::SLOT_N; i++) begin : g_slot
        // an accepted write is also committed to the store
        always_ff @(posedge sys_clk) begin
            if (nvm_init) begin
                nv_q[i] <= mur_pkg::SLOT_RST[i];
            end else if (wr_en && wr_slot == 3'(i)) begin
                nv_q[i] <= wdata;
            end
        end
        // volatile copy answers reads at once
        always_ff @(posedge sys_clk) begin
            if (nvm_init) begin
                vol_q[i] <= mur_pkg::SLOT_RST[i];
            end else if (srst) begin
                vol_q[i] <= nv_q[i];
            end else if (wr_en && wr_slot == 3'(i)) begin
                vol_q[i] <= wdata;
            end
        end
        // the working copy reloads only on restart
        always_ff @(posedge sys_clk) begin
            if (nvm_init) begin
                act_q[i] <= mur_pkg::SLOT_RST[i];
            end else if (srst) begin
                act_q[i] <= nv_q[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data mux, sharing the slot decode of the write path
    always_comb begin
        rd_data = 16'h0000;
        if (acc_num == mur_pkg::REG_FW) begin
            rd_data = FW_REV;
        // code register reads back the last code
        end else if (acc_num == mur_pkg::REG_CODE) begin
            rd_data = code_q;
        end else if (wr_slot != mur_pkg::SLOT_NONE) begin
            rd_data = vol_q[wr_slot];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // answer bytes; in process mode they carry the error flag and current
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            status_byte_q       <= 8'h00;
            device_input_word_q <= 16'h0000;
        end else if (pd_strobe) begin
            if (!ctrl_byte[mur_pkg::CTRL_MODE_BIT]) begin
                // error flag in the status byte
                status_byte_q <= err_led_q ? mur_pkg::STAT_ERR_MASK : 8'h00;
                device_input_word_q <= scaled_current_q;
            end else if (acc_go) begin
                if (acc_wr) begin
                    // write ack clears the direction bit
                    status_byte_q <= ctrl_byte & ~mur_pkg::CTRL_WR_MASK;
                    // no data after a write, zero is driven
                    device_input_word_q <= 16'h0000;
                end else begin
                    // read ack echoes the control byte
                    status_byte_q <= ctrl_byte;
                    device_input_word_q <= rd_data;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // undervoltage detection
    // compare against the working threshold
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            err_led_q <= 1'b0;
        end else begin
            err_led_q <= (mains_voltage < act_q[mur_pkg::S_UVTH]);
        end
    end
    // energy unit select follows the working entry
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            energy_scale_q <= mur_pkg::SLOT_RST[mur_pkg::S_ESCALE][2:0];
        end else begin
            energy_scale_q <= act_q[mur_pkg::S_ESCALE][2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // current scaling; a zero divisor falls back to 1:1 to avoid garbage
    // scaling only when the feature bit is set
    assign scale_en = act_q[mur_pkg::S_FEAT][mur_pkg::FEAT_SCALE_BIT]
                      && (act_q[mur_pkg::S_TDIV] != 16'h0000);
    assign div.start    = scale_en && !div.busy;
    assign div.dividend = meas_current;
    assign div.divisor  = act_q[mur_pkg::S_TDIV];
    mur_divider u_div (
        .sys_clk (sys_clk),
        .srst    (srst),
        .div     (div)
    );
    // divided result, else the raw current
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            scaled_current_q <= 16'h0000;
        end else if (!scale_en) begin
            scaled_current_q <= meas_current;
        end else if (div.done) begin
            scaled_current_q <= div.quotient;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // millisecond enable pulse shared by both interval timers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ms_cnt_q  <= '0;
            ms_tick_q <= 1'b0;
        end else if (ms_cnt_q == PS_W'(MS_CYCLES - 1)) begin
            ms_cnt_q  <= '0;
            ms_tick_q <= 1'b1;
        end else begin
            ms_cnt_q  <= ms_cnt_q + 1'b1;
            ms_tick_q <= 1'b0;
        end
    end
    // measuring cycle in 1 ms steps
    mur_interval #(.CNT_W(mur_pkg::TMR_W)) u_meas (
        .sys_clk (sys_clk),
        .srst    (srst),
        .tick    (ms_tick_q),
        .enable  (1'b1),
        .period  (mur_pkg::TMR_W'(act_q[mur_pkg::S_MCYC])),
        .fire_q  (meas_fire)
    );
    // min/max clear in 10 ms steps when enabled
    mur_interval #(.CNT_W(mur_pkg::TMR_W)) u_minmax (
        .sys_clk (sys_clk),
        .srst    (srst),
        .tick    (ms_tick_q),
        .enable  (act_q[mur_pkg::S_FEAT][mur_pkg::FEAT_AUTOCLR_BIT]),
        .period  (mur_pkg::TMR_W'(act_q[mur_pkg::S_MMPER]
                  * mur_pkg::MINMAX_RES_MS)),
        .fire_q  (mm_fire)
    );
    // timer pulses leave through local flops
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            measure_tick_q <= 1'b0;
            minmax_clear_q <= 1'b0;
        end else begin
            measure_tick_q <= meas_fire;
            minmax_clear_q <= mm_fire;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // checks; sampled srst in antecedents skips the reset release edge
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst || nvm_init);
    AST_ESCALE_RANGE: assert property (
        vol_q[mur_pkg::S_ESCALE] <= mur_pkg::ESCALE_MAX)
        else $error("energy scale entry out of range");
    AST_UV_FLAG: assert property (
        !srst && (mains_voltage < act_q[mur_pkg::S_UVTH]) |=> err_led_q)
        else $error("undervoltage not flagged");
    AST_UV_STATUS: assert property (
        pd_strobe && !ctrl_byte[7] |=> status_byte_q[6] == $past(err_led_q))
        else $error("error bit missing from status byte");
    AST_NOSCALE: assert property (
        !srst && !scale_en |=> scaled_current_q == $past(meas_current))
        else $error("current scaled while scaling off");
    AST_RD_ACK: assert property (
        acc_go && !acc_wr |=> status_byte_q == $past(ctrl_byte))
        else $error("read ack differs from control byte");
    AST_WR_ACK: assert property (
        acc_go && acc_wr |=> status_byte_q == ($past(ctrl_byte) & 8'hBF))
        else $error("write ack wrong");
    AST_HOLD: assert property (
        pd_strobe && held_q && ctrl_byte == last_ctrl_q
        |=> $stable(status_byte_q) && $stable(device_input_word_q))
        else $error("repeated control byte changed the answer");
    AST_LOCKED: assert property (
        locked && acc_go && acc_wr && acc_num == mur_pkg::REG_UVTH
        |=> $stable(vol_q[mur_pkg::S_UVTH]) && $stable(nv_q[mur_pkg::S_UVTH]))
        else $error("write accepted while protected");
    AST_UNLOCK: assert property (
        acc_go && acc_wr && acc_num == mur_pkg::REG_CODE
        |=> locked == ($past(host_output_word) != 16'h1235))
        else $error("protection state wrong after code write");
    AST_ACT_HOLD: assert property (
        1'b1 |=> $stable(act_q[mur_pkg::S_MCYC]))
        else $error("working value changed without restart");
    AST_CODE_RD: assert property (
        acc_go && !acc_wr && acc_num == mur_pkg::REG_CODE
        |=> device_input_word_q == $past(code_q))
        else $error("code read back wrong");
    AST_FW_RD: assert property (
        acc_go && !acc_wr && acc_num == mur_pkg::REG_FW
        |=> device_input_word_q == FW_REV)
        else $error("revision read wrong");
    AST_UNMAPPED: assert property (
        acc_go && !acc_wr && acc_num > mur_pkg::REG_MCYC
        |=> device_input_word_q == 16'h0000)
        else $error("unmapped register not zero");
endmodule

// ===== mur_coupler.sv
// fieldbus coupler model issuing process data exchanges
`timescale 1ns/1ps
module mur_coupler (
    input  wire logic        sys_clk,
    input  wire logic [7:0]  status_byte_q,
    input  wire logic [15:0] device_input_word_q,
    output logic             pd_strobe,
    output logic [7:0]       ctrl_byte,
    output logic [15:0]      host_output_word
);
    logic [7:0] last_ctrl = 8'h00;
    ////////////////////////////////////////////////////////////////////
    // quiet bus until the first exchange
    initial begin
        pd_strobe = 1'b0;
        ctrl_byte = 8'h00;
        host_output_word = 16'h0000;
    end
    // one strobe, answer taken after the edge that samples it
    task automatic send(input logic [7:0] c, input logic [15:0] d,
                        output logic [7:0] st, output logic [15:0] wd);
        @(posedge sys_clk);
        pd_strobe <= 1'b1;
        ctrl_byte <= c;
        host_output_word <= d;
        @(posedge sys_clk);
        pd_strobe <= 1'b0;
        // released word must not keep showing the value
        host_output_word <= ~d;
        #1;
        st = status_byte_q;
        wd = device_input_word_q;
        last_ctrl = c;
    endtask
    // a repeated register byte would count as already served
    task automatic xfer(input logic [7:0] c, input logic [15:0] d,
                        input bit keep, output logic [7:0] st,
                        output logic [15:0] wd);
        if (!keep && c[7] && c == last_ctrl)
            send(8'h00, 16'h0000, st, wd);
        send(c, d, st, wd);
    endtask
endmodule

// ===== mur_regaccess_tb_top.sv
// self-checking bench for the register access block
`timescale 1ns/1ps
module mur_regaccess_tb_top;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        nvm_init = 1'b1;
    logic [15:0] mains_voltage = 16'h0058;
    logic [15:0] meas_current = 16'h0064;
    logic        pd_strobe, err_led_q, measure_tick_q, minmax_clear_q;
    logic [7:0]  ctrl_byte, status_byte_q, st;
    logic [15:0] host_output_word, device_input_word_q, scaled_current_q;
    logic [15:0] wd;
    logic [2:0]  energy_scale_q;
    int          n_fail = 0;
    int          n_checks = 0;
    int          n;
    // locked writes first, unlock midway, relock last
    // control, data, expected status, expected word
    logic [47:0] rows [30] = '{48'h89FFFF893030, 48'hA30000A30004,
        48'hA40000A40064, 48'hA50000A50001, 48'hA60000A600C8,
        48'hA70000A70032, 48'hA00000A00000, 48'h9F00009F0000,
        48'hE40050A40000, 48'hA40000A40064, 48'hDF12359F0000,
        48'h9F00009F1235, 48'hE40050A40000, 48'hA4FFFFA40050,
        48'hE30007A30000, 48'hA30000A30004, 48'hE30006A30000,
        48'hA30000A30006, 48'hE0FFFFA00000, 48'hA00000A000FD,
        48'hE00081A00000, 48'hA00000A00081, 48'hE50002A50000,
        48'hE70002A70000, 48'hE60001A60000, 48'hC91111890000,
        48'h890000893030, 48'hFA5555BA0000, 48'hBA0000BA0000,
        48'hDF00009F0000};

    always #25 sys_clk = ~sys_clk;

    mur_regaccess #(.MS_CYCLES(20)) u_dut (
        .sys_clk(sys_clk), .srst(srst), .nvm_init(nvm_init),
        .pd_strobe(pd_strobe), .ctrl_byte(ctrl_byte),
        .host_output_word(host_output_word),
        .mains_voltage(mains_voltage), .meas_current(meas_current),
        .status_byte_q(status_byte_q),
        .device_input_word_q(device_input_word_q),
        .err_led_q(err_led_q), .energy_scale_q(energy_scale_q),
        .scaled_current_q(scaled_current_q),
        .measure_tick_q(measure_tick_q), .minmax_clear_q(minmax_clear_q));

    mur_coupler u_host (
        .sys_clk(sys_clk), .status_byte_q(status_byte_q),
        .device_input_word_q(device_input_word_q),
        .pd_strobe(pd_strobe), .ctrl_byte(ctrl_byte),
        .host_output_word(host_output_word));

    ////////////////////////////////////////////////////////////////////
    // verdict in one place only
    task automatic summarize;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // compare with case equality so unknowns never match
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // cycles until the next pulse, bounded against a dead timer
    task automatic gap(input bit mm, output int cnt);
        cnt = 0;
        while ((mm ? minmax_clear_q : measure_tick_q) !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            cnt++;
            if (cnt > 1000) begin
                n_fail++;
                summarize();
            end
        end
    endtask
    task automatic acc(input logic [7:0] c, input logic [15:0] d);
        u_host.xfer(c, d, 1'b0, st, wd);
    endtask

    ////////////////////////////////////////////////////////////////////
    // table first, then repeat, restart and timer cases
    initial begin
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        nvm_init <= 1'b0;
        for (int i = 0; i < 30; i++) begin
            acc(rows[i][47:40], rows[i][39:24]);
            chk({8'h00, st}, {8'h00, rows[i][23:16]});
            chk(wd, rows[i][15:0]);
        end
        $display("register table test done");
        acc(8'hDF, 16'h1235);
        u_host.xfer(8'hDF, 16'h0000, 1'b1, st, wd);
        acc(8'h9F, 16'h0000);
        chk(wd, 16'h1235);
        acc(8'hDF, 16'h0000);
        $display("repeat test done");
        chk({13'h0000, energy_scale_q}, 16'h0004);
        chk({15'h0000, err_led_q}, 16'h0001);
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (40) @(posedge sys_clk);
        #1;
        chk({13'h0000, energy_scale_q}, 16'h0006);
        chk({15'h0000, err_led_q}, 16'h0000);
        chk(scaled_current_q, 16'h0032);
        acc(8'h9F, 16'h0000);
        chk(wd, 16'h0000);
        acc(8'h00, 16'h0000);
        chk({8'h00, st}, 16'h0000);
        chk(wd, 16'h0032);
        @(posedge sys_clk);
        mains_voltage <= 16'h004F;
        repeat (3) @(posedge sys_clk);
        acc(8'h00, 16'h0000);
        chk({8'h00, st}, 16'h0040);
        $display("restart test done");
        gap(1'b0, n);
        @(posedge sys_clk);
        #1;
        gap(1'b0, n);
        chk(16'(n + 1), 16'h0028);
        gap(1'b1, n);
        @(posedge sys_clk);
        #1;
        gap(1'b1, n);
        chk(16'(n + 1), 16'h00C8);
        $display("timer test done");
        summarize();
    end
endmodule
